// file: design/periodic_timebase.sv
// Periodic timebase: divider chain, pending flag, AXI4-Lite control and interrupt
`timescale 1ns/1ps

module periodic_timebase (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ref_clk_tick,
    input wire timebase_pkg::power_cfg_type power_cfg,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic timebase_irq,
    output logic irq
);
    import timebase_pkg::*;

    // ==========================================================
    // Declarations
    // ==========================================================
    logic [1:0] tick_sync_r;  // Reference tick synchroniser
    logic tick_prev_r;  // Previous synchronised tick level
    logic ref_edge;  // One-cycle enable per reference edge
    power_cfg_type cfg_s1_r;  // Power config first stage
    power_cfg_type cfg_r;  // Power config second stage
    logic [6:0] pre_cnt_r;  // Divide-by-128 prescaler
    logic count_en;  // Chain advance enable
    logic [CHAIN_BITS-1:0] chain_r;  // Divider chain
    logic rollover;  // Tap rising edge
    logic run_en_r;  // Run enable
    logic irq_en_r;  // Interrupt enable
    logic [2:0] rate_r;  // Tap rate select
    logic flag_r;  // Pending flag
    logic [1:0] ev_status_r;  // Sticky event status
    logic [1:0] ev_mask_r;  // Event mask
    logic reg_blocked;  // CPU access refused in low power
    logic running;  // Chain allowed to run in this power state
    wr_state_type wr_state_r;  // Write channel state
    logic aw_got_r;  // Write address held
    logic w_got_r;  // Write data held
    logic [3:0] aw_addr_r;  // Captured write address
    logic [31:0] w_data_r;  // Captured write data
    logic w_strb0_r;  // Low byte lane enable
    logic wr_fire;  // Write performed this cycle
    logic ctrl_wr;  // Control low byte written
    logic stat_wr;  // Status low byte written
    logic ack_wr;  // Acknowledge written as one

    // ==========================================================
    // Reference clock: two-flop sync then edge enable
    // ==========================================================
    // Tick comes from the clock generator, another domain; only the
    // second stage feeds the edge detector.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_sync_r <= 2'b00;
            tick_prev_r <= 1'b0;
        end else begin
            tick_sync_r <= {tick_sync_r[0], ref_clk_tick};
            tick_prev_r <= tick_sync_r[1];
        end
    end

    assign ref_edge = tick_sync_r[1] & ~tick_prev_r;

    // Configuration pins come from outside the clock domain
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_s1_r <= '0;
            cfg_r <= '0;
        end else begin
            cfg_s1_r <= power_cfg;
            cfg_r <= cfg_s1_r;
        end
    end

    // ==========================================================
    // Power state
    // ==========================================================
    // Stop without oscillator halts everything; wait keeps counting
    assign running = ~cfg_r.stop_mode | cfg_r.oscillator_run_in_stop;
    assign reg_blocked = cfg_r.wait_mode | cfg_r.stop_mode;

    // ==========================================================
    // Prescaler: optional divide by 128 of the reference
    // ==========================================================
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_cnt_r <= '0;
        end else if (!run_en_r) begin
            pre_cnt_r <= '0;
        end else if (ref_edge && running) begin
            pre_cnt_r <= pre_cnt_r + 7'd1;
        end
    end

    // Chain advances per reference edge, or per 128 of them
    assign count_en = ref_edge & running & run_en_r &
        (~cfg_r.prescale_128_select | (pre_cnt_r == PRE_LAST));

    // ==========================================================
    // Divider chain
    // ==========================================================
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chain_r <= '0;
        end else if (!run_en_r) begin
            chain_r <= '0;
        end else if (count_en) begin
            chain_r <= chain_r + 15'd1;
        end
    end

    // Tap decode; rising edge of the tap gives half-period first event
    tap_select u_tap (
        .aclk(aclk),
        .aresetn(aresetn),
        .chain(chain_r),
        .rate(rate_r),
        .rollover(rollover)
    );

    // ==========================================================
    // Write channel: address and data in either order
    // ==========================================================
    assign wr_fire = (wr_state_r == WR_IDLE) && aw_got_r && w_got_r;
    assign ctrl_wr = wr_fire && !reg_blocked && aw_addr_r == CTRL_ADDR && w_strb0_r;
    assign stat_wr = wr_fire && !reg_blocked && aw_addr_r == IRQ_STATUS_ADDR && w_strb0_r;
    assign ack_wr = ctrl_wr & w_data_r[ACK_BIT];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_r <= WR_IDLE;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            aw_addr_r <= '0;
            w_data_r <= '0;
            w_strb0_r <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            case (wr_state_r)
                WR_IDLE: begin
                    s_axi_awready <= !aw_got_r && !(s_axi_awvalid && s_axi_awready);
                    s_axi_wready <= !w_got_r && !(s_axi_wvalid && s_axi_wready);
                    // Capture address
                    if (s_axi_awvalid && s_axi_awready) begin
                        aw_got_r <= 1'b1;
                        aw_addr_r <= s_axi_awaddr;
                    end
                    // Capture data
                    if (s_axi_wvalid && s_axi_wready) begin
                        w_got_r <= 1'b1;
                        w_data_r <= s_axi_wdata;
                        w_strb0_r <= s_axi_wstrb[0];
                    end
                    // Both present: perform and answer
                    if (wr_fire) begin
                        aw_got_r <= 1'b0;
                        w_got_r <= 1'b0;
                        s_axi_awready <= 1'b0;
                        s_axi_wready <= 1'b0;
                        s_axi_bvalid <= 1'b1;
                        if (reg_blocked || !(aw_addr_r == CTRL_ADDR ||
                                aw_addr_r == IRQ_STATUS_ADDR || aw_addr_r == IRQ_MASK_ADDR)) begin
                            s_axi_bresp <= RESP_SLVERR;
                        end else begin
                            s_axi_bresp <= RESP_OKAY;
                        end
                        wr_state_r <= WR_RESP;
                    end
                end
                WR_RESP: begin
                    // Hold response until taken
                    if (s_axi_bready) begin
                        s_axi_bvalid <= 1'b0;
                        wr_state_r <= WR_IDLE;
                    end
                end
                default: begin
                    wr_state_r <= WR_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Control fields
    // ==========================================================
    // Rate is written regardless of run state; keeping it still while
    // running is left to software, a change mid-run may glitch one event.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_en_r <= 1'b0;
            irq_en_r <= 1'b0;
            rate_r <= RATE_RESET;
        end else if (ctrl_wr) begin
            run_en_r <= w_data_r[RUN_EN_BIT];
            irq_en_r <= w_data_r[IRQ_EN_BIT];
            rate_r <= w_data_r[RATE_LSB +: 3];
        end
    end

    // Mask register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ev_mask_r <= MASK_RESET;
        end else if (wr_fire && !reg_blocked && aw_addr_r == IRQ_MASK_ADDR && w_strb0_r) begin
            ev_mask_r <= w_data_r[1:0];
        end
    end

    // ==========================================================
    // Pending flag: set wins over acknowledge
    // ==========================================================
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_r <= 1'b0;
        end else if (rollover) begin
            flag_r <= 1'b1;
        end else if (ack_wr) begin
            flag_r <= 1'b0;
        end
    end

    // Sticky status: rollover and wake-from-stop; write one clears
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ev_status_r <= '0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (stat_wr && w_data_r[i]) begin
                    ev_status_r[i] <= 1'b0;
                end
            end
            if (rollover) begin
                ev_status_r[EV_ROLL_BIT] <= 1'b1;
            end
            if (rollover && cfg_r.stop_mode) begin
                ev_status_r[EV_WAKE_BIT] <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Interrupt outputs, registered
    // ==========================================================
    // Next-state form so timebase_irq follows the flag without lag; irq follows the masked status, one cycle late on a clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timebase_irq <= 1'b0;
            irq <= 1'b0;
        end else begin
            timebase_irq <= irq_en_r && (rollover || (flag_r && !ack_wr));
            irq <= |(ev_mask_r & ev_status_r) || (|(ev_mask_r & {rollover && cfg_r.stop_mode,
                rollover}));
        end
    end

    // ==========================================================
    // Read channel: one cycle to answer
    // ==========================================================
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_rvalid) begin
            // Hold answer until taken
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= '0;
            if (reg_blocked) begin
                s_axi_rresp <= RESP_SLVERR;
            end else begin
                case (s_axi_araddr)
                    // Acknowledge bit reads zero
                    CTRL_ADDR: s_axi_rdata <= {24'h00_0000, flag_r, rate_r, 1'b0,
                        irq_en_r, run_en_r, 1'b0};
                    IRQ_STATUS_ADDR: s_axi_rdata <= {30'h0000_0000, ev_status_r};
                    IRQ_MASK_ADDR: s_axi_rdata <= {30'h0000_0000, ev_mask_r};
                    default: s_axi_rresp <= RESP_SLVERR;
                endcase
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    sequence ack_write_s;
        ack_wr && !rollover;
    endsequence

    flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rollover |=> flag_r) else $error("flag not set on rollover");
    flag_ack_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ack_write_s |=> !flag_r) else $error("flag not cleared by ack");
    flag_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
        flag_r && !ack_wr |=> flag_r) else $error("flag lost without ack");
    hold_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !run_en_r |=> chain_r == '0) else $error("chain not held at zero");
    irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
        timebase_irq |-> $past(irq_en_r)) else $error("irq without enable");
    irq_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
        irq_en_r && flag_r && !ack_wr ##1 irq_en_r |-> timebase_irq)
        else $error("irq missing with flag and enable");
    stop_halt_a: assert property (@(posedge aclk) disable iff (!aresetn)
        cfg_r.stop_mode && !cfg_r.oscillator_run_in_stop |=> $stable(chain_r))
        else $error("chain moved in stop");
    blocked_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && reg_blocked |=> s_axi_rresp == RESP_SLVERR)
        else $error("blocked read answered okay");
    ack_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> !s_axi_rdata[ACK_BIT]) else $error("ack bit read as one");

endmodule : periodic_timebase

// file: include/timebase_pkg.sv
// Package: register map, field layout and timing constants of the periodic timebase
package timebase_pkg;

    // ==========================================================
    // Register map (byte addresses on the AXI4-Lite slave)
    // ==========================================================
    localparam logic [3:0] CTRL_ADDR = 4'h0;  // Timebase control register
    localparam logic [3:0] IRQ_STATUS_ADDR = 4'h4;  // Sticky event status, write one to clear
    localparam logic [3:0] IRQ_MASK_ADDR = 4'h8;  // Mask for the interrupt output

    // ==========================================================
    // Control register field positions
    // ==========================================================
    localparam int FLAG_BIT = 7;  // Pending flag, read only
    localparam int RATE_LSB = 4;  // Tap rate select, three bits
    localparam int ACK_BIT = 3;  // Acknowledge, write only
    localparam int IRQ_EN_BIT = 2;  // Interrupt enable
    localparam int RUN_EN_BIT = 1;  // Run enable

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [2:0] RATE_RESET = 3'h0;  // Slowest tap after reset
    localparam logic [1:0] MASK_RESET = 2'h0;  // All events masked after reset

    // ==========================================================
    // Status bits of the interrupt status register
    // ==========================================================
    localparam int EV_ROLL_BIT = 0;  // Rollover event
    localparam int EV_WAKE_BIT = 1;  // Rollover seen while in stop

    // ==========================================================
    // Counter and prescaler sizes
    // ==========================================================
    localparam int CHAIN_BITS = 15;  // Divider chain stages
    localparam int PRE_DIV = 128;  // Extra prescale figure
    localparam logic [6:0] PRE_LAST = 7'h7F;  // Terminal count of the prescaler

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;  // Access done
    localparam logic [1:0] RESP_SLVERR = 2'h2;  // Unmapped or blocked access

    // Power state of the core, set by the system around the block
    typedef struct packed {
        logic wait_mode;  // Core in wait
        logic stop_mode;  // Core in stop
        logic oscillator_run_in_stop;  // Oscillator kept running in stop
        logic prescale_128_select;  // Extra divide by 128
    } power_cfg_type;

    // Write channel state
    typedef enum logic [1:0] {
        WR_IDLE = 2'b00,
        WR_RESP = 2'b01
    } wr_state_type;

endpackage : timebase_pkg

// file: design/tap_select.sv
// Tap decoder: picks the counter bit whose rising edge marks one period
`timescale 1ns/1ps

module tap_select (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [timebase_pkg::CHAIN_BITS-1:0] chain,
    input wire logic [2:0] rate,
    output logic rollover
);
    import timebase_pkg::*;

    // ==========================================================
    // Tap index for each rate code
    // ==========================================================
    // Divider 2^(idx+1): codes map to 32768,8192,2048,128,64,32,16,8
    function automatic logic [3:0] tap_index(input logic [2:0] code);
        case (code)
            3'd0: tap_index = 4'd14;  // 32768
            3'd1: tap_index = 4'd12;  // 8192
            3'd2: tap_index = 4'd10;  // 2048
            3'd3: tap_index = 4'd6;  // 128
            3'd4: tap_index = 4'd5;  // 64
            3'd5: tap_index = 4'd4;  // 32
            3'd6: tap_index = 4'd3;  // 16
            default: tap_index = 4'd2;  // 8
        endcase
    endfunction : tap_index

    logic tap_now;  // Selected tap this cycle
    logic tap_last_r;  // Selected tap one cycle ago

    assign tap_now = chain[tap_index(rate)];

    // ==========================================================
    // Rising edge of the tap is one rollover
    // ==========================================================
    // A tap bit goes 0 -> 1 once per full divider period, and first after
    // half of it from a cleared chain; a falling edge would also fire when
    // run enable clears the chain.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tap_last_r <= 1'b0;
        end else begin
            tap_last_r <= tap_now;
        end
    end

    assign rollover = ~tap_last_r & tap_now;

endmodule : tap_select

// file: sim/tb.sv
// Self-checking bench of the periodic timebase over its AXI4-Lite slave
`timescale 1ns/1ps

module tb;
    import timebase_pkg::*;

    // ==========================================
    // Clock, reset, stimulus signals
    // ==========================================
    logic aclk = 1'b0;  // 40 MHz bus clock
    logic aresetn = 1'b0;  // Held low at start
    logic ref_clk_tick = 1'b0;  // Reference clock, one rise per 8 aclk
    power_cfg_type power_cfg = '0;  // Power state and prescale option
    logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = '0;
    logic [31:0] s_axi_wdata = '0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, d;
    logic timebase_irq, irq;
    int fails = 0, n_checks = 0;  // Mismatch and comparison counters
    int tick_n = 0;  // Reference rises since start
    logic [1:0] ref_div = '0;  // Half-period counter of the reference

    periodic_timebase dut (.aclk(aclk), .aresetn(aresetn), .ref_clk_tick(ref_clk_tick),
        .power_cfg(power_cfg), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .timebase_irq(timebase_irq), .irq(irq));

    // Clock generator, 25 ns period
    always #12.5 aclk = ~aclk;

    // Reference well below aclk/4 so the synchroniser never drops a rise
    always @(posedge aclk) begin
        ref_div <= ref_div + 2'h1;
        if (ref_div == 2'h3) begin
            ref_clk_tick <= ~ref_clk_tick;
            if (!ref_clk_tick) tick_n <= tick_n + 1;  // Count rising edges only
        end
    end

    // ==========================================
    // Helpers
    // ==========================================
    // Compare and report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            fails++;
        end
    endtask : chk

    // Control word builder
    function automatic logic [31:0] cv(input int r, input bit ie, input bit run, input bit ack);
        logic [31:0] v;
        v = '0;
        v[RATE_LSB+:3] = r[2:0];
        v[IRQ_EN_BIT] = ie;
        v[RUN_EN_BIT] = run;
        v[ACK_BIT] = ack;
        return v;
    endfunction : cv

    // Write: address and data offered together, each released once taken
    task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s,
        input logic [1:0] er);
        int k;
        bit aw_ok, w_ok;
        aw_ok = 0;
        w_ok = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (k = 0; k < 200 && !(aw_ok && w_ok); k++) begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1 && !aw_ok) begin
                aw_ok = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready === 1'b1 && !w_ok) begin
                w_ok = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        // Bready stays up until the response is seen
        s_axi_bready <= 1'b1;
        for (k = 0; k < 200 && s_axi_bvalid !== 1'b1; k++) @(posedge aclk);
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
        if (k >= 200) fails++;  // Hung handshake
    endtask : wr

    // Read: address held until taken, rready held until data seen
    task automatic rd(input logic [3:0] a, input logic [1:0] er, output logic [31:0] v);
        int k;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (k = 0; k < 200; k++) begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) break;
        end
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        for (k = 0; k < 200 && s_axi_rvalid !== 1'b1; k++) @(posedge aclk);
        v = s_axi_rdata;
        s_axi_rready <= 1'b0;
        chk({30'h0, s_axi_rresp}, {30'h0, er});
        if (k >= 200) fails++;  // Hung handshake
    endtask : rd

    // Wait for a fresh rise of the timebase request, bounded
    task automatic wait_irq();
        int k;
        for (k = 0; k < 40000 && timebase_irq !== 1'b0; k++) @(posedge aclk);
        if (k >= 40000) fails++;  // Request never dropped
        for (k = 0; k < 40000 && timebase_irq !== 1'b1; k++) @(posedge aclk);
        if (k >= 40000) fails++;  // No event arrived
    endtask : wait_irq

    // Restart at code c and time first event and one full period in ticks
    task automatic measure(input int c, input int div);
        int ts, t0;
        logic [31:0] d0;
        // Stop first with the old rate kept; the new rate goes in with the run write
        rd(CTRL_ADDR, RESP_OKAY, d0);
        wr(CTRL_ADDR, (d0 & 32'h0000_0070) | cv(0, 1, 0, 1), 4'hF, RESP_OKAY);
        wr(CTRL_ADDR, cv(c, 1, 1, 0), 4'hF, RESP_OKAY);
        ts = tick_n;
        wait_irq();
        t0 = tick_n;
        // One tick may already sit in the synchroniser when ts is taken
        chk(32'(t0 - ts >= div / 2 - 1 && t0 - ts <= div / 2), 32'h1);
        wr(CTRL_ADDR, cv(c, 1, 1, 1), 4'hF, RESP_OKAY);
        wait_irq();
        chk(32'(tick_n - t0), 32'(div));
    endtask : measure

    // Closing report and verdict
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : wrap_up

    // Watchdog sized well above the roughly 1 ms the tests take
    initial begin
        #2_000_000;
        fails++;
        wrap_up();
    end

    // ==========================================
    // Test sequence
    // ==========================================
    initial begin
        int div_tab[8] = '{32768, 8192, 2048, 128, 64, 32, 16, 8};
        int pre_tab[8] = '{4194304, 1048576, 262144, 16384, 8192, 4096, 2048, 1024};
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(CTRL_ADDR, RESP_OKAY, d);
        chk(d, 32'h0000_0000);
        rd(IRQ_MASK_ADDR, RESP_OKAY, d);
        chk(d, 32'h0000_0000);
        // Rate field stored, acknowledge not stored
        wr(CTRL_ADDR, cv(5, 1, 0, 1), 4'hF, RESP_OKAY);
        rd(CTRL_ADDR, RESP_OKAY, d);
        chk(d, cv(5, 1, 0, 0));
        // Unmapped place and empty strobe
        rd(4'hC, RESP_SLVERR, d);
        wr(4'hC, 32'h0000_00FF, 4'hF, RESP_SLVERR);
        wr(CTRL_ADDR, cv(2, 0, 0, 0), 4'h0, RESP_OKAY);
        rd(CTRL_ADDR, RESP_OKAY, d);
        chk(d, cv(5, 1, 0, 0));
        // Periods without prescale, shortest five taps
        for (int c = 3; c < 8; c++) measure(c, div_tab[c]);
        // Flag held, request gated by enable, acknowledge zero ignored
        wr(CTRL_ADDR, cv(7, 0, 0, 0), 4'hF, RESP_OKAY);
        repeat (4) @(posedge aclk);
        chk({31'h0, timebase_irq}, 32'h0);
        rd(CTRL_ADDR, RESP_OKAY, d);
        chk(d, 32'h0000_0070 | (32'h1 << FLAG_BIT));
        rd(IRQ_STATUS_ADDR, RESP_OKAY, d);
        chk(d & 32'h1, 32'h1);
        chk({31'h0, irq}, 32'h0);  // Masked
        wr(IRQ_MASK_ADDR, 32'h0000_0001, 4'hF, RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk({31'h0, irq}, 32'h1);
        wr(IRQ_STATUS_ADDR, 32'h0000_0001, 4'hF, RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        wr(CTRL_ADDR, cv(7, 1, 0, 1), 4'hF, RESP_OKAY);
        rd(CTRL_ADDR, RESP_OKAY, d);
        chk(d, cv(7, 1, 0, 0));
        // Stopped counter raises nothing over many periods
        repeat (600) @(posedge aclk);
        chk({31'h0, timebase_irq}, 32'h0);
        // Wait mode: counting goes on, register blocked
        wr(CTRL_ADDR, cv(7, 1, 1, 0), 4'hF, RESP_OKAY);
        power_cfg.wait_mode <= 1'b1;
        repeat (4) @(posedge aclk);
        wr(CTRL_ADDR, cv(7, 1, 1, 1), 4'hF, RESP_SLVERR);
        rd(CTRL_ADDR, RESP_SLVERR, d);
        wait_irq();
        power_cfg.wait_mode <= 1'b0;
        repeat (4) @(posedge aclk);
        // Stop with oscillator running keeps waking
        wr(CTRL_ADDR, cv(7, 1, 1, 1), 4'hF, RESP_OKAY);
        wr(IRQ_STATUS_ADDR, 32'h0000_0003, 4'hF, RESP_OKAY);
        power_cfg.oscillator_run_in_stop <= 1'b1;
        power_cfg.stop_mode <= 1'b1;
        wait_irq();
        power_cfg.stop_mode <= 1'b0;
        repeat (4) @(posedge aclk);
        rd(IRQ_STATUS_ADDR, RESP_OKAY, d);
        chk(d & 32'h2, 32'h2);
        // Stop without oscillator: inactive and blocked
        wr(CTRL_ADDR, cv(7, 1, 1, 1), 4'hF, RESP_OKAY);
        power_cfg.oscillator_run_in_stop <= 1'b0;
        power_cfg.stop_mode <= 1'b1;
        repeat (4) @(posedge aclk);
        rd(CTRL_ADDR, RESP_SLVERR, d);
        repeat (600) @(posedge aclk);
        chk({31'h0, timebase_irq}, 32'h0);
        power_cfg.stop_mode <= 1'b0;
        repeat (4) @(posedge aclk);
        // Prescale option, changed only while stopped
        wr(CTRL_ADDR, cv(7, 1, 0, 1), 4'hF, RESP_OKAY);
        power_cfg.prescale_128_select <= 1'b1;
        repeat (4) @(posedge aclk);
        for (int c = 6; c < 8; c++) measure(c, pre_tab[c]);
        wrap_up();
    end

endmodule : tb
